// ---- logic/sdpc_mem.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sdpc_regs.svh"
module sdpc_mem (
  // clock
  input wire logic clk,
  // nibble write enables
  input wire logic we_lo,
  input wire logic we_hi,
  // shared address and write data
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  // registered read data
  output logic [7:0] rdata
);
  logic [7:0] mem_q [`SDPC_MEM_WORDS];

  // nibble-wise write, read data from a register
  always_ff @(posedge clk) begin
    if (we_lo)
      mem_q[addr][3:0] <= wdata[3:0];
    if (we_hi)
      mem_q[addr][7:4] <= wdata[7:4];
    rdata <= mem_q[addr];
  end
endmodule
`default_nettype wire

// ---- logic/sdpc_pkg.sv ----
`default_nettype none
package sdpc_pkg;

  // ************************************************
  // power states, one-hot
  // ************************************************
  typedef enum logic [2:0] {
    PW_ON     = 3'b001,
    PW_PD_PRE = 3'b010,
    PW_PD_ACT = 3'b100
  } sdpc_pw_t;

  // ************************************************
  // decoded commands, one-hot
  // ************************************************
  typedef enum logic [7:0] {
    CMD_MRS = 8'h01,
    CMD_REF = 8'h02,
    CMD_PRE = 8'h04,
    CMD_ACT = 8'h08,
    CMD_WR  = 8'h10,
    CMD_RD  = 8'h20,
    CMD_ZQ  = 8'h40,
    CMD_NOP = 8'h80
  } sdpc_cmd_t;

  // command and address pins sampled together
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [13:0] addr;
  } sdpc_cmd_pins_t;

  // input receiver enables
  typedef struct packed {
    logic clk;
    logic gate;
    logic term;
    logic cmd;
    logic data;
  } sdpc_rx_en_t;

endpackage
`default_nettype wire

// ---- logic/sdpc_regs.svh ----
`ifndef SDPC_REGS_SVH
`define SDPC_REGS_SVH
// How it works
// - clock-gate high enables, low disables circuitry
// - gate low: idle banks precharge/self refresh, else active
// - power-down and self refresh entry sampled on clock
// - self refresh exits on gate rise, no clock
// - power-down keeps clock, gate, reset, termination receivers
// - self refresh keeps only gate and reset receivers
// - chip select low enables decoder, high masks
// - command from select, row, column, write strobes
// - masked write beats are discarded
// - termination strobe option disables write mask in x8
// - termination enable switches lane/strobe/mask termination
// - termination enable ignored when mode disables it
// - reset asserts and releases without clock
// - read strobes edge-aligned with read data
// - data bus eight lanes x8, four x4
// - no-function balls: unused x8, upper lanes x4
// - inputs sampled at rising true clock crossing

// ************************************************
// burst and memory shape
// ************************************************
`define SDPC_LAST_BEAT 3'h7
`define SDPC_MEM_WORDS 64
`define SDPC_LANES_X8 8'hFF
`define SDPC_LANES_X4 8'h0F

// ************************************************
// mode register fields and precharge-all bit
// ************************************************
`define SDPC_MR_TERM_BANK 3'h1
`define SDPC_MR_TSOPT_BIT 11
`define SDPC_MR_RTT0_BIT 2
`define SDPC_MR_RTT1_BIT 6
`define SDPC_MR_RTT2_BIT 9
`define SDPC_PRE_ALL_BIT 10
`define SDPC_RTT_RST 3'h0
`define SDPC_TSOPT_RST 1'b0
`endif

// ---- logic/sdpc_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sdpc_regs.svh"
module sdpc_top (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // width strap, high for x8
  input wire logic x8_strap,
  // clock gate
  input wire logic cke,
  // command and address
  input wire sdpc_pkg::sdpc_cmd_pins_t cmd_pins,
  // termination enable and write mask
  input wire logic term_enable,
  input wire logic write_mask,
  // data lanes
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic [7:0] dq_oe,
  // strobe pair
  input wire logic dqs_in,
  output logic dqs_p_out,
  output logic dqs_n_out,
  output logic dqs_oe,
  // status
  output sdpc_pkg::sdpc_pw_t power_state,
  output logic self_refresh,
  output sdpc_pkg::sdpc_rx_en_t rx_en,
  output logic term_on,
  output logic term_strobe_on,
  output logic x8_mode
);
  import sdpc_pkg::*;

  // ************************************************
  // command decode
  // ************************************************
  function automatic sdpc_cmd_t sdpc_decode(input sdpc_cmd_pins_t p);
    sdpc_cmd_t c;
    c = CMD_NOP;
    unique case ({p.ras_n, p.cas_n, p.we_n})
      3'h0: c = CMD_MRS;
      3'h1: c = CMD_REF;
      3'h2: c = CMD_PRE;
      3'h3: c = CMD_ACT;
      3'h4: c = CMD_WR;
      3'h5: c = CMD_RD;
      3'h6: c = CMD_ZQ;
      3'h7: c = CMD_NOP;
    endcase
    return c;
  endfunction

  sdpc_pw_t pw_q, pw_d;
  logic sr_q;
  logic cfg_done_q, x8_q;
  logic [2:0] rtt_q;
  logic tsopt_q;
  logic [7:0] bank_open_q;
  logic wr_act_q, rd_act_q, rd_pipe_q;
  logic [2:0] cnt_q;
  logic [2:0] bank_q;
  logic [7:0] rdata;
  logic [7:0] dq_out_q, dq_oe_q;
  logic dqs_p_q, dqs_n_q, dqs_oe_q;
  sdpc_rx_en_t rx_q;
  logic term_q, tstr_q;

  // ************************************************
  // sampled command and power decisions
  // ************************************************
  wire sdpc_cmd_t cmd = sdpc_decode(cmd_pins);
  wire any_open = |bank_open_q;
  wire busy = wr_act_q | rd_act_q | rd_pipe_q;
  // decoder alive only when powered, out of self refresh
  wire cmd_live = pw_q == PW_ON && !sr_q && cfg_done_q;
  wire cmd_sel = cmd_live && !cmd_pins.cs_n;
  wire cmd_go = cmd_sel && cke;
  wire sre_go = cmd_sel && !cke && cmd == CMD_REF && !any_open;
  wire pd_go = cmd_live && !cke && !sre_go;
  wire abort = pd_go | sre_go;
  wire sr_next = (sr_q | sre_go) && !cke;
  wire bank_ok = bank_open_q[cmd_pins.ba];
  wire wr_go = cmd_go && cmd == CMD_WR && bank_ok && !busy;
  wire rd_go = cmd_go && cmd == CMD_RD && bank_ok && !busy;
  wire mrs_go = cmd_go && cmd == CMD_MRS && !busy;
  wire pre_all = cmd_pins.addr[`SDPC_PRE_ALL_BIT];

  // ************************************************
  // write path decode
  // ************************************************
  wire [7:0] lanes = x8_q ? `SDPC_LANES_X8 : `SDPC_LANES_X4;
  wire mask_on = write_mask && !(x8_q && tsopt_q);
  wire beat_take = wr_act_q && dqs_in;
  wire we_lo = beat_take && !mask_on;
  wire we_hi = beat_take && !mask_on && x8_q;
  wire last = cnt_q == `SDPC_LAST_BEAT;

  // ************************************************
  // termination and receiver enables
  // ************************************************
  wire term_d = rtt_q != `SDPC_RTT_RST && term_enable
    && !sr_next;
  wire tstr_d = term_d && x8_q && tsopt_q;
  wire on_next = pw_d == PW_ON && !sr_next;
  wire sdpc_rx_en_t rx_d = '{clk: !sr_next, gate: 1'b1, term: !sr_next,
                             cmd: on_next, data: on_next};

  // ************************************************
  // power state machine
  // ************************************************
  // next power state
  always_comb begin
    pw_d = pw_q;
    unique case (pw_q)
      PW_ON: if (pd_go) pw_d = any_open ? PW_PD_ACT : PW_PD_PRE;
      PW_PD_PRE, PW_PD_ACT: if (cke) pw_d = PW_ON;
      default: pw_d = PW_ON;
    endcase
  end

  // power state register, reset without clock
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      pw_q <= PW_ON;
    else
      pw_q <= pw_d;
  end

  // self refresh, left as soon as the gate rises
  always_ff @(posedge sys_clk or negedge arst_n or posedge cke) begin
    if (!arst_n)
      sr_q <= 1'b0;
    else if (cke)
      sr_q <= 1'b0;
    else if (sre_go)
      sr_q <= 1'b1;
  end

  // width strap caught once after release
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_done_q <= 1'b0;
      x8_q <= 1'b0;
    end else if (!cfg_done_q) begin
      cfg_done_q <= 1'b1;
      x8_q <= x8_strap;
    end
  end

  // ************************************************
  // mode bits and bank state
  // ************************************************
  // termination mode and strobe option
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rtt_q <= `SDPC_RTT_RST;
      tsopt_q <= `SDPC_TSOPT_RST;
    end else if (mrs_go && cmd_pins.ba == `SDPC_MR_TERM_BANK) begin
      rtt_q <= {cmd_pins.addr[`SDPC_MR_RTT2_BIT],
                cmd_pins.addr[`SDPC_MR_RTT1_BIT],
                cmd_pins.addr[`SDPC_MR_RTT0_BIT]};
      tsopt_q <= cmd_pins.addr[`SDPC_MR_TSOPT_BIT];
    end
  end

  // open rows per bank
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      bank_open_q <= 8'h00;
    else if (cmd_go && cmd == CMD_ACT)
      bank_open_q[cmd_pins.ba] <= 1'b1;
    else if (cmd_go && cmd == CMD_PRE && pre_all)
      bank_open_q <= 8'h00;
    else if (cmd_go && cmd == CMD_PRE)
      bank_open_q[cmd_pins.ba] <= 1'b0;
  end

  // ************************************************
  // burst control
  // ************************************************
  // write and read burst flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
      rd_pipe_q <= 1'b0;
    end else begin
      wr_act_q <= wr_go | (wr_act_q && !(beat_take && last) && !abort);
      rd_act_q <= rd_go | (rd_act_q && !last && !abort);
      rd_pipe_q <= rd_act_q;
    end
  end

  // beat counter and burst bank
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 3'h0;
      bank_q <= 3'h0;
    end else if (wr_go | rd_go) begin
      cnt_q <= 3'h0;
      bank_q <= cmd_pins.ba;
    end else if (beat_take | rd_act_q) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // burst storage
  sdpc_mem u_mem (
    .clk(sys_clk),
    .we_lo(we_lo),
    .we_hi(we_hi),
    .addr({bank_q, cnt_q}),
    .wdata(dq_in),
    .rdata(rdata)
  );

  // ************************************************
  // read drive
  // ************************************************
  // lanes and strobes driven only with read data
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dq_out_q <= 8'h00;
      dq_oe_q <= 8'h00;
      dqs_oe_q <= 1'b0;
    end else begin
      dq_out_q <= rd_pipe_q ? (rdata & lanes) : 8'h00;
      dq_oe_q <= rd_pipe_q ? lanes : 8'h00;
      dqs_oe_q <= rd_pipe_q;
    end
  end

  // strobe toggles on the edge that moves the data
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dqs_p_q <= 1'b0;
      dqs_n_q <= 1'b1;
    end else begin
      dqs_p_q <= rd_pipe_q ? !dqs_p_q : 1'b0;
      dqs_n_q <= rd_pipe_q ? dqs_p_q : 1'b1;
    end
  end

  // status registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_q <= '{clk: 1'b1, gate: 1'b1, term: 1'b1, cmd: 1'b1, data: 1'b1};
      term_q <= 1'b0;
      tstr_q <= 1'b0;
    end else begin
      rx_q <= rx_d;
      term_q <= term_d;
      tstr_q <= tstr_d;
    end
  end

  // output wiring
  assign dq_out = dq_out_q;
  assign dq_oe = dq_oe_q;
  assign dqs_p_out = dqs_p_q;
  assign dqs_n_out = dqs_n_q;
  assign dqs_oe = dqs_oe_q;
  assign power_state = pw_q;
  assign self_refresh = sr_q;
  assign rx_en = rx_q;
  assign term_on = term_q;
  assign term_strobe_on = tstr_q;
  assign x8_mode = x8_q;

  // ************************************************
  // checks
  // ************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  cs_mask_a:
    assert property (cmd_live && cmd_pins.cs_n && cke |=>
      $stable(bank_open_q) && $stable(rtt_q) && !$rose(wr_act_q))
    else $error("command taken with chip select high");

  pd_idle_a:
    assert property (pd_go && !any_open |=> pw_q == PW_PD_PRE)
    else $error("precharge power-down not entered");

  pd_open_a:
    assert property (pd_go && any_open |=> pw_q == PW_PD_ACT)
    else $error("active power-down not entered");

  pd_exit_a:
    assert property (pw_q != PW_ON && cke |=> pw_q == PW_ON && rx_en.cmd)
    else $error("power-down not left on gate high");

  sr_exit_a:
    assert property (cke |-> !sr_q)
    else $error("self refresh held with gate high");

  sr_rx_a:
    assert property (sre_go |=> sr_q && !rx_en.clk && !rx_en.cmd
      && rx_en.gate)
    else $error("receivers left on in self refresh");

  pd_rx_a:
    assert property (pd_go |=> rx_en.clk && rx_en.term && !rx_en.data)
    else $error("wrong receivers in power-down");

  oe_read_a:
    assert property (dqs_oe || dq_oe != 8'h00 |-> $past(rd_pipe_q))
    else $error("lanes driven outside a read");

  strobe_edge_a:
    assert property (dqs_oe && $past(dqs_oe) |->
      dqs_p_out != $past(dqs_p_out) && dqs_n_out == !dqs_p_out)
    else $error("strobe not toggling with read data");

  read_len_a:
    assert property ($rose(dqs_oe) |-> dqs_oe [*8] ##1 !dqs_oe)
    else $error("read burst not eight beats");

  mask_drop_a:
    assert property (beat_take && write_mask && !(x8_q && tsopt_q)
      |-> !we_lo && !we_hi)
    else $error("masked beat written");

  x4_lanes_a:
    assert property (!x8_q |-> dq_oe[7:4] == 4'h0 && !we_hi && !term_strobe_on)
    else $error("upper lanes used in x4");

  term_off_a:
    assert property (rtt_q == `SDPC_RTT_RST |=> !term_on)
    else $error("termination on while disabled by mode");

  term_on_a:
    assert property (rtt_q != `SDPC_RTT_RST && term_enable && cke && !sr_q
      |=> term_on)
    else $error("termination not following enable");

endmodule
`default_nettype wire

// ---- test/sdpc_ctrl_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module sdpc_ctrl_model (
  // clock from the bench
  input wire logic clk,
  // pins driven into the device
  output logic cke,
  output sdpc_pkg::sdpc_cmd_pins_t pins,
  output logic term_enable,
  output logic write_mask,
  output logic [7:0] dq,
  output logic dqs
);
  import sdpc_pkg::*;
  // ********
  // idle levels, device deselected
  // ********
  initial begin
    cke = 1'b1;
    pins = {4'hF, 3'h0, 14'h0000};
    term_enable = 1'b0;
    write_mask = 1'b0;
    dq = 8'h00;
    dqs = 1'b0;
  end
  // one command code per edge, held across the rising edge
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
                     input logic [13:0] a);
    @(negedge clk);
    pins <= {c, b, a};
  endtask
  // clock gate and termination request levels
  task automatic lv(input logic c, input logic t);
    @(negedge clk);
    cke <= c;
    term_enable <= t;
  endtask
  // eight beats, strobe high across the middle of each
  task automatic burst(input logic [7:0] base, input logic [7:0] msk);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      pins <= {4'h7, 3'h0, 14'h0000};
      dqs <= 1'b1;
      dq <= base + 8'(i);
      write_mask <= msk[i];
    end
    @(negedge clk);
    dqs <= 1'b0;
    write_mask <= 1'b0;
    dq <= ~dq; // released lanes do not keep the last beat
  endtask
endmodule
`default_nettype wire

// ---- test/sdpc_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: %h not %h", $time, a, e); end end
module sdpc_top_tb;
  import sdpc_pkg::*;
  localparam logic [3:0] C_MRS = 4'h0, C_REF = 4'h1, C_PRE = 4'h2;
  localparam logic [3:0] C_ACT = 4'h3, C_WR = 4'h4, C_RD = 4'h5;
  localparam logic [3:0] C_NOP = 4'h7, C_RD_DESEL = 4'hD, C_ZQ = 4'h6;
  logic sys_clk, arst_n, x8_strap, cke, term_enable, write_mask, dqs_in;
  logic dqs_p_out, dqs_n_out, dqs_oe, self_refresh, term_on;
  logic term_strobe_on, x8_mode;
  logic [7:0] dq_in, dq_out, dq_oe;
  logic [7:0] exp_w [8];
  sdpc_cmd_pins_t cmd_pins;
  sdpc_pw_t power_state;
  sdpc_rx_en_t rx_en;
  int fail_count = 0;
  int checks = 0;
  // ********
  // clock, controller model and device
  // ********
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  sdpc_ctrl_model ctrl (.clk(sys_clk), .cke(cke), .pins(cmd_pins),
    .term_enable(term_enable), .write_mask(write_mask), .dq(dq_in),
    .dqs(dqs_in));
  sdpc_top DUT (.sys_clk(sys_clk), .arst_n(arst_n), .x8_strap(x8_strap),
    .cke(cke), .cmd_pins(cmd_pins), .term_enable(term_enable),
    .write_mask(write_mask), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .dqs_in(dqs_in), .dqs_p_out(dqs_p_out),
    .dqs_n_out(dqs_n_out), .dqs_oe(dqs_oe), .power_state(power_state),
    .self_refresh(self_refresh), .rx_en(rx_en), .term_on(term_on),
    .term_strobe_on(term_strobe_on), .x8_mode(x8_mode));
  // ********
  // shared steps
  // ********
  task automatic do_reset(input logic s);
    arst_n = 1'b0;
    x8_strap = s;
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask
  // read a burst and compare the lanes that oe drives
  task automatic rd_check(input logic [7:0] oe, input logic [2:0] b);
    ctrl.cmd(C_RD, b, 14'h0000);
    ctrl.cmd(C_NOP, 3'h0, 14'h0000);
    @(negedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      @(negedge sys_clk);
      `CHK(dq_out & oe, exp_w[i] & oe)
      `CHK(dq_oe, oe)
      `CHK({dqs_oe, dqs_p_out, dqs_n_out}, {1'b1, ~i[0], i[0]})
    end
    @(negedge sys_clk);
    `CHK({dq_oe, dqs_oe}, 9'h000)
  endtask
  // ********
  // scenarios
  // ********
  task automatic test_write_read();
    `CHK(x8_mode, 1'b1)
    ctrl.cmd(C_ACT, 3'h2, 14'h0000);
    ctrl.cmd(C_WR, 3'h2, 14'h0000);
    ctrl.burst(8'h10, 8'h00);
    ctrl.cmd(C_WR, 3'h2, 14'h0000);
    ctrl.burst(8'h80, 8'h08);
    ctrl.cmd(C_RD_DESEL, 3'h2, 14'h0000);
    ctrl.cmd(C_ZQ, 3'h2, 14'h0000);
    repeat (2) @(negedge sys_clk);
    `CHK(dqs_oe, 1'b0)
    for (int i = 0; i < 8; i++) exp_w[i] = 8'h80 + 8'(i);
    exp_w[3] = 8'h13;
    rd_check(8'hFF, 3'h2);
    $display("done: write_read");
  endtask
  task automatic test_term();
    ctrl.cmd(C_MRS, 3'h1, 14'h0804);
    ctrl.lv(1'b1, 1'b1);
    repeat (2) @(negedge sys_clk);
    `CHK({term_on, term_strobe_on}, 2'b11)
    ctrl.cmd(C_ACT, 3'h3, 14'h0000);
    ctrl.cmd(C_WR, 3'h3, 14'h0000);
    ctrl.burst(8'h40, 8'hFF);
    for (int i = 0; i < 8; i++) exp_w[i] = 8'h40 + 8'(i);
    rd_check(8'hFF, 3'h3);
    ctrl.lv(1'b1, 1'b0);
    repeat (2) @(negedge sys_clk);
    `CHK(term_on, 1'b0)
    ctrl.cmd(C_MRS, 3'h1, 14'h0000);
    ctrl.lv(1'b1, 1'b1);
    repeat (2) @(negedge sys_clk);
    `CHK({term_on, term_strobe_on}, 2'b00)
    $display("done: term");
  endtask
  task automatic test_power();
    ctrl.cmd(C_NOP, 3'h0, 14'h0000);
    ctrl.lv(1'b0, 1'b1);
    @(negedge sys_clk);
    `CHK(power_state, PW_PD_ACT)
    @(negedge sys_clk);
    `CHK(rx_en, 5'b11100)
    ctrl.lv(1'b1, 1'b0);
    @(negedge sys_clk);
    `CHK(power_state, PW_ON)
    @(negedge sys_clk);
    `CHK(rx_en, 5'b11111)
    ctrl.cmd(C_PRE, 3'h0, 14'h0400);
    ctrl.cmd(C_NOP, 3'h0, 14'h0000);
    ctrl.lv(1'b0, 1'b0);
    @(negedge sys_clk);
    `CHK(power_state, PW_PD_PRE)
    ctrl.lv(1'b1, 1'b0);
    ctrl.cmd(C_REF, 3'h0, 14'h0000);
    ctrl.lv(1'b0, 1'b0);
    @(negedge sys_clk);
    `CHK(self_refresh, 1'b1)
    ctrl.cmd(C_NOP, 3'h0, 14'h0000);
    `CHK(rx_en, 5'b01000)
    ctrl.lv(1'b1, 1'b0);
    #1;
    `CHK(self_refresh, 1'b0)
    $display("done: power");
  endtask
  task automatic test_x4();
    ctrl.cmd(C_ACT, 3'h2, 14'h0000);
    ctrl.cmd(C_RD, 3'h2, 14'h0000);
    ctrl.cmd(C_NOP, 3'h0, 14'h0000);
    repeat (2) @(negedge sys_clk);
    `CHK(dqs_oe, 1'b1)
    arst_n = 1'b0;
    #1;
    `CHK({dq_oe, dqs_oe}, 9'h000)
    do_reset(1'b0);
    `CHK(x8_mode, 1'b0)
    ctrl.cmd(C_ACT, 3'h1, 14'h0000);
    ctrl.cmd(C_WR, 3'h1, 14'h0000);
    ctrl.burst(8'hF0, 8'h00);
    for (int i = 0; i < 8; i++) exp_w[i] = 8'hF0 + 8'(i);
    rd_check(8'h0F, 3'h1);
    $display("done: x4");
  endtask
  // ********
  // verdict
  // ********
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #(3000 * 50);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    do_reset(1'b1);
    test_write_read();
    test_term();
    test_power();
    test_x4();
    tally_and_finish();
  end
endmodule
`default_nettype wire
